/* File: per_pkg.sv */
`default_nettype none
package per_pkg;
   localparam logic [7:0] OFS_EVENT_SELECT = 8'h00;
   localparam logic [7:0] OFS_RANGE_START = 8'h04;
   localparam logic [7:0] OFS_RANGE_END = 8'h08;
   localparam logic [7:0] OFS_STATUS_WORD = 8'h0C;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   localparam logic [7:0] OFS_EVENT_CODE = 8'h18;
   localparam logic [7:0] OFS_EVENT_ADDR = 8'h1C;
   localparam logic [11:0] LOC_EVENT_CODE = 12'h096;
   localparam logic [11:0] LOC_EVENT_ADDR = 12'h099;
   localparam int SEL_BRANCH = 31;
   localparam int SEL_GREG = 30;
   localparam int SEL_IFETCH = 29;
   localparam int SEL_STORE = 28;
   localparam int STATUS_MON_ENABLE = 1;
   localparam int STATUS_EXT_CONTROL = 12;
   localparam int STATUS_TRANSLATE = 5;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef struct packed {
      logic valid;
      logic branch_taken;
      logic [15:0] greg_written;
      logic ifetch;
      logic store;
      logic [23:0] instr_addr;
      logic [23:0] ifetch_vaddr;
      logic [23:0] ifetch_raddr;
      logic [23:0] store_vaddr;
      logic [23:0] store_raddr;
   } exec_report_type;
   typedef struct packed {
      logic valid;
      logic [3:0] code;
      logic [23:0] instr_addr;
   } per_record_type;
endpackage
`default_nettype wire

/* File: range_check.sv */
`default_nettype none
module range_check #(
   parameter int WIDTH = 24
) (
   input wire logic [WIDTH-1:0] addr,
   input wire logic [WIDTH-1:0] start_addr,
   input wire logic [WIDTH-1:0] end_addr,
   output logic hit
);
   // Both bounds inclusive; a start above end wraps around the top
   always_comb begin
      if (start_addr <= end_addr) begin
         hit = (addr >= start_addr) && (addr <= end_addr);
      end else begin
         hit = (addr >= start_addr) || (addr <= end_addr);
      end
   end
endmodule
`default_nettype wire

/* File: program_event_recorder.sv */
// Function
// (RQ1) Detection happens only in extended control mode with status word bit 1 set.
// (RQ2) Branches, general register writes, fetches in range and stores in range are detected.
// (RQ3) Select bits 0 to 3 of event_select_and_register_mask enable each event type.
// (RQ4) An interruption is raised only when enable bit and matching select bit are both one.
// (RQ5) Bits 16 to 31 of event_select_and_register_mask pick the watched general registers.
// (RQ6) The watched range runs from watch_range_start to watch_range_end.
// (RQ7) The event code is written to low storage location 150.
// (RQ8) The instruction address is written to low storage locations 153 to 155.
// (RQ9) Events seen while disabled are dropped and never held pending.
// (RQ10) Range compares use virtual addresses when translation is on or in assist mode.
// (RQ11) Status word bit 12 selects basic or extended control mode.
// (RQ12) Several events in one instruction are all flagged; range bounds are inclusive.
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`default_nettype none
module program_event_recorder (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire per_pkg::exec_report_type exec_report,
   input wire logic assist_mode,
   output per_pkg::per_record_type per_record,
   output logic per_interrupt_req,
   output logic [11:0] low_store_addr,
   output logic [7:0] low_store_data,
   output logic low_store_valid,
   output logic irq
);
   logic [31:0] event_select_and_register_mask;
   logic [31:0] watch_range_start;
   logic [31:0] watch_range_end;
   logic [31:0] program_status_word;
   logic [3:0] irq_status;
   logic [3:0] irq_mask;
   logic [3:0] last_code;
   logic [23:0] last_addr;
   logic aw_held;
   logic w_held;
   logic [7:0] aw_off;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;
   logic [3:0] clear_bits;

   // Write address and data may arrive in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_off <= 8'h00;
         w_data <= per_pkg::RESET_WORD;
         w_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_off <= s_axi_awaddr[7:0];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
         end
      end
   end

   assign do_write = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= per_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            unique case (aw_off)
               per_pkg::OFS_EVENT_SELECT, per_pkg::OFS_RANGE_START,
               per_pkg::OFS_RANGE_END, per_pkg::OFS_STATUS_WORD,
               per_pkg::OFS_IRQ_STATUS, per_pkg::OFS_IRQ_MASK,
               per_pkg::OFS_EVENT_CODE, per_pkg::OFS_EVENT_ADDR: begin
                  s_axi_bresp <= per_pkg::RESP_OKAY;
               end
               default: begin
                  s_axi_bresp <= per_pkg::RESP_SLVERR;
               end
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] result;
      result = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            result[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return result;
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         event_select_and_register_mask <= per_pkg::RESET_WORD;
         watch_range_start <= per_pkg::RESET_WORD;
         watch_range_end <= per_pkg::RESET_WORD;
         program_status_word <= per_pkg::RESET_WORD;
         irq_mask <= 4'h0;
      end else if (do_write) begin
         unique case (aw_off)
            per_pkg::OFS_EVENT_SELECT: begin
               event_select_and_register_mask <=
                  merge(event_select_and_register_mask, w_data, w_strb); // [RQ3] [RQ5]
            end
            per_pkg::OFS_RANGE_START: begin
               watch_range_start <= merge(watch_range_start, w_data, w_strb); // [RQ6]
            end
            per_pkg::OFS_RANGE_END: begin
               watch_range_end <= merge(watch_range_end, w_data, w_strb); // [RQ6]
            end
            per_pkg::OFS_STATUS_WORD: begin
               program_status_word <= merge(program_status_word, w_data, w_strb);
            end
            per_pkg::OFS_IRQ_MASK: begin
               if (w_strb[0]) begin
                  irq_mask <= w_data[3:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   assign clear_bits = (do_write && aw_off == per_pkg::OFS_IRQ_STATUS && w_strb[0]) ?
                       w_data[3:0] : 4'h0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= per_pkg::RESET_WORD;
         s_axi_rresp <= per_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= per_pkg::RESP_OKAY;
            unique case (s_axi_araddr[7:0])
               per_pkg::OFS_EVENT_SELECT: s_axi_rdata <= event_select_and_register_mask;
               per_pkg::OFS_RANGE_START: s_axi_rdata <= watch_range_start;
               per_pkg::OFS_RANGE_END: s_axi_rdata <= watch_range_end;
               per_pkg::OFS_STATUS_WORD: s_axi_rdata <= program_status_word;
               per_pkg::OFS_IRQ_STATUS: s_axi_rdata <= {28'h0000000, irq_status};
               per_pkg::OFS_IRQ_MASK: s_axi_rdata <= {28'h0000000, irq_mask};
               per_pkg::OFS_EVENT_CODE: s_axi_rdata <= {28'h0000000, last_code};
               per_pkg::OFS_EVENT_ADDR: s_axi_rdata <= {8'h00, last_addr};
               default: begin
                  s_axi_rdata <= per_pkg::RESET_WORD;
                  s_axi_rresp <= per_pkg::RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Event detection
   logic monitor_active;
   logic use_virtual;
   logic [23:0] fetch_addr;
   logic [23:0] store_addr;
   logic fetch_hit;
   logic store_hit;
   logic [3:0] next_code;

   assign monitor_active = program_status_word[31 - per_pkg::STATUS_EXT_CONTROL] &&
                           program_status_word[31 - per_pkg::STATUS_MON_ENABLE]; // [RQ1] [RQ11]
   assign use_virtual = assist_mode ||
                        program_status_word[31 - per_pkg::STATUS_TRANSLATE]; // [RQ10]
   assign fetch_addr = use_virtual ? exec_report.ifetch_vaddr : exec_report.ifetch_raddr;
   assign store_addr = use_virtual ? exec_report.store_vaddr : exec_report.store_raddr;

   range_check #(.WIDTH(24)) fetch_range (
      .addr(fetch_addr),
      .start_addr(watch_range_start[23:0]),
      .end_addr(watch_range_end[23:0]),
      .hit(fetch_hit)
   );

   range_check #(.WIDTH(24)) store_range (
      .addr(store_addr),
      .start_addr(watch_range_start[23:0]),
      .end_addr(watch_range_end[23:0]),
      .hit(store_hit)
   );

   // Disabled events vanish here rather than queue
   always_comb begin
      next_code = 4'h0;
      if (exec_report.valid && monitor_active) begin // [RQ1] [RQ9]
         next_code[3] = exec_report.branch_taken &&
                        event_select_and_register_mask[per_pkg::SEL_BRANCH]; // [RQ2] [RQ4]
         next_code[2] = |(exec_report.greg_written &
                          event_select_and_register_mask[15:0]) &&
                        event_select_and_register_mask[per_pkg::SEL_GREG]; // [RQ5]
         next_code[1] = exec_report.ifetch && fetch_hit &&
                        event_select_and_register_mask[per_pkg::SEL_IFETCH]; // [RQ6] [RQ12]
         next_code[0] = exec_report.store && store_hit &&
                        event_select_and_register_mask[per_pkg::SEL_STORE]; // [RQ6] [RQ12]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         per_record <= '0;
         per_interrupt_req <= 1'b0;
         last_code <= 4'h0;
         last_addr <= 24'h000000;
      end else begin
         per_interrupt_req <= |next_code; // [RQ4]
         per_record.valid <= |next_code;
         per_record.code <= next_code; // [RQ12]
         per_record.instr_addr <= exec_report.instr_addr;
         if (|next_code) begin
            last_code <= next_code;
            last_addr <= exec_report.instr_addr;
         end
      end
   end

   // Low storage writer: code byte then three address bytes
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CODE = 3'b001,
      ST_A0 = 3'b011,
      ST_A1 = 3'b010,
      ST_A2 = 3'b110
   } store_state_type;
   store_state_type store_state;
   logic [3:0] pend_code;
   logic [23:0] pend_addr;

   // A new event during the writer's sequence is dropped; only ST_IDLE loads pend_code
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         store_state <= ST_IDLE;
         pend_code <= 4'h0;
         pend_addr <= 24'h000000;
         low_store_valid <= 1'b0;
         low_store_addr <= 12'h000;
         low_store_data <= 8'h00;
      end else begin
         low_store_valid <= 1'b0;
         unique case (store_state)
            ST_IDLE: begin
               if (|next_code) begin
                  pend_code <= next_code;
                  pend_addr <= exec_report.instr_addr;
                  store_state <= ST_CODE;
               end
            end
            ST_CODE: begin
               low_store_valid <= 1'b1;
               low_store_addr <= per_pkg::LOC_EVENT_CODE; // [RQ7]
               low_store_data <= {pend_code, 4'h0};
               store_state <= ST_A0;
            end
            ST_A0: begin
               low_store_valid <= 1'b1;
               low_store_addr <= per_pkg::LOC_EVENT_ADDR; // [RQ8]
               low_store_data <= pend_addr[23:16];
               store_state <= ST_A1;
            end
            ST_A1: begin
               low_store_valid <= 1'b1;
               low_store_addr <= 12'(per_pkg::LOC_EVENT_ADDR + 12'h001); // [RQ8]
               low_store_data <= pend_addr[15:8];
               store_state <= ST_A2;
            end
            ST_A2: begin
               low_store_valid <= 1'b1;
               low_store_addr <= 12'(per_pkg::LOC_EVENT_ADDR + 12'h002); // [RQ8]
               low_store_data <= pend_addr[7:0];
               store_state <= ST_IDLE;
            end
            default: begin
               store_state <= ST_IDLE;
            end
         endcase
      end
   end

   // Set wins over a write-one clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= 4'h0;
         irq <= 1'b0;
      end else begin
         irq_status <= (irq_status & ~clear_bits) | next_code;
         irq <= |(((irq_status & ~clear_bits) | next_code) & irq_mask);
      end
   end

   AST_DISABLED_SILENT: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ1]
      !monitor_active |=> !per_interrupt_req)
      else $error("event raised while monitor disabled");
   AST_BRANCH_RAISES: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ2]
      exec_report.valid && monitor_active && exec_report.branch_taken &&
      event_select_and_register_mask[per_pkg::SEL_BRANCH] |=> per_record.code[3])
      else $error("enabled branch not flagged");
   AST_SELECT_GATES: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ3]
      !event_select_and_register_mask[per_pkg::SEL_STORE] |=> !per_record.code[0])
      else $error("store flagged while not selected");
   AST_REQ_MATCHES_CODE: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ4]
      exec_report.valid && monitor_active && event_select_and_register_mask[per_pkg::SEL_GREG] &&
      (exec_report.greg_written & event_select_and_register_mask[15:0]) != 16'h0000
      |=> per_interrupt_req)
      else $error("enabled register write raised no request");
   AST_GREG_MASK: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ5]
      (exec_report.greg_written & event_select_and_register_mask[15:0]) == 16'h0000
      |=> !per_record.code[2])
      else $error("unwatched register flagged");
   AST_CODE_STORED: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ7]
      store_state == ST_IDLE && (|next_code) |-> ##2 low_store_valid &&
      low_store_addr == per_pkg::LOC_EVENT_CODE)
      else $error("event code not stored");
   AST_ADDR_STORED: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ8]
      low_store_valid && low_store_addr == per_pkg::LOC_EVENT_CODE |=>
      low_store_valid && low_store_addr == per_pkg::LOC_EVENT_ADDR ##1
      low_store_valid ##1 low_store_valid && low_store_data == pend_addr[7:0])
      else $error("instruction address not stored");
   AST_NO_PENDING: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ9]
      !monitor_active && store_state == ST_IDLE |=> store_state == ST_IDLE)
      else $error("disabled event held pending");
endmodule
`default_nettype wire

/* File: exec_unit_model.sv */
`default_nettype none
module exec_unit_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire per_pkg::exec_report_type cmd,
   input wire logic cmd_go,
   input wire logic [11:0] low_store_addr,
   input wire logic [7:0] low_store_data,
   input wire logic low_store_valid,
   output per_pkg::exec_report_type exec_report
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] low_mem [0:4095];
   logic [23:0] junk;
   // Idle fields keep moving so the design cannot lean on stale values
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         junk <= 24'h5A5A5A;
         exec_report <= '0;
      end else if (cmd_go) begin
         exec_report <= cmd;
      end else begin
         junk <= ~junk;
         exec_report <= {1'b0, junk[18:0], junk, junk, junk, junk, junk};
      end
   end
   always_ff @(posedge aclk) begin
      if (low_store_valid) begin
         low_mem[low_store_addr] <= low_store_data;
      end
   end
endmodule
`default_nettype wire

/* File: testbench.sv */
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] MON_EN = 32'h1 << (31 - per_pkg::STATUS_MON_ENABLE);
   localparam logic [31:0] EXT_CTL = 32'h1 << (31 - per_pkg::STATUS_EXT_CONTROL);
   localparam logic [31:0] XLATE = 32'h1 << (31 - per_pkg::STATUS_TRANSLATE);
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, assist_mode, cmd_go, irq;
   logic per_interrupt_req, low_store_valid;
   logic [31:0] awaddr, wdata, araddr, rdata, rdat;
   logic [1:0] bresp, rresp, resp;
   logic [11:0] low_store_addr;
   logic [7:0] low_store_data;
   per_pkg::exec_report_type cmd, exec_report;
   per_pkg::per_record_type per_record;
   int err_count = 0;
   int num_checks = 0;

   program_event_recorder program_event_recorder_i (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .exec_report(exec_report), .assist_mode(assist_mode), .per_record(per_record),
      .per_interrupt_req(per_interrupt_req), .low_store_addr(low_store_addr),
      .low_store_data(low_store_data), .low_store_valid(low_store_valid), .irq(irq));
   exec_unit_model exec_unit_model_i (.aclk(aclk), .aresetn(aresetn), .cmd(cmd),
      .cmd_go(cmd_go), .low_store_addr(low_store_addr), .low_store_data(low_store_data),
      .low_store_valid(low_store_valid), .exec_report(exec_report));

   task automatic give_verdict;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok, w_ok, b_ok;
      aw_ok = 0;
      w_ok = 0;
      b_ok = 0;
      awaddr <= {24'h0, a};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b_ok) begin
         @(posedge aclk);
         if (!aw_ok && awready === 1'b1) begin
            awvalid <= 1'b0;
            aw_ok = 1;
         end
         if (!w_ok && wready === 1'b1) begin
            wvalid <= 1'b0;
            w_ok = 1;
         end
         if (bvalid === 1'b1) begin
            resp = bresp;
            b_ok = 1;
         end
      end
   endtask

   task automatic rd(input logic [7:0] a);
      logic ar_ok, r_ok;
      ar_ok = 0;
      r_ok = 0;
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!r_ok) begin
         @(posedge aclk);
         if (!ar_ok && arready === 1'b1) begin
            arvalid <= 1'b0;
            ar_ok = 1;
         end
         if (rvalid === 1'b1) begin
            rdat = rdata;
            resp = rresp;
            r_ok = 1;
         end
      end
   endtask

   // k: branch, unused, fetch, store; g: written registers
   function automatic per_pkg::exec_report_type ev(input logic [3:0] k, input logic [15:0] g,
      input logic [23:0] ia, input logic [23:0] va, input logic [23:0] ra);
      ev = '0;
      ev.valid = 1'b1;
      ev.branch_taken = k[3];
      ev.greg_written = g;
      ev.ifetch = k[1];
      ev.store = k[0];
      ev.instr_addr = ia;
      ev.ifetch_vaddr = va;
      ev.store_vaddr = va;
      ev.ifetch_raddr = ra;
      ev.store_raddr = ra;
   endfunction

   task automatic fire(input per_pkg::exec_report_type r, input logic [3:0] exp);
      logic seen;
      seen = 0;
      cmd <= r;
      cmd_go <= 1'b1;
      @(posedge aclk);
      cmd_go <= 1'b0;
      repeat (4) begin
         @(posedge aclk);
         if (per_interrupt_req === 1'b1) begin
            seen = 1;
            check(per_record.valid, 1);
            check(per_record.code, exp);
            check(per_record.instr_addr, r.instr_addr);
         end
      end
      check(seen, exp != 4'h0);
      repeat (6) @(posedge aclk);
      if (exp != 4'h0) begin
         check(exec_unit_model_i.low_mem[12'h096], {exp, 4'h0});
         check(exec_unit_model_i.low_mem[12'h099], r.instr_addr[23:16]);
         check(exec_unit_model_i.low_mem[12'h09A], r.instr_addr[15:8]);
         check(exec_unit_model_i.low_mem[12'h09B], r.instr_addr[7:0]);
      end
   endtask

   task automatic t_regs;
      for (int i = 0; i < 8; i++) begin
         rd(8'(i * 4));
         check(rdat, per_pkg::RESET_WORD);
      end
      wr(per_pkg::OFS_RANGE_START, 32'h00A5_5A5A);
      check(resp, per_pkg::RESP_OKAY);
      rd(per_pkg::OFS_RANGE_START);
      check(rdat, 32'h00A5_5A5A);
      rd(8'h40);
      check(resp, per_pkg::RESP_SLVERR);
      check(rdat, 32'h0);
      wr(8'h40, 32'h1234_5678);
      check(resp, per_pkg::RESP_SLVERR);
   endtask

   task automatic t_gate;
      wr(per_pkg::OFS_EVENT_SELECT, 32'hF000_FFFF);
      wr(per_pkg::OFS_RANGE_START, 32'h0);
      wr(per_pkg::OFS_RANGE_END, 32'h00FF_FFFF);
      wr(per_pkg::OFS_STATUS_WORD, 32'h0);
      fire(ev(4'h8, 16'h0, 24'h000100, 24'h0, 24'h0), 4'h0);
      wr(per_pkg::OFS_STATUS_WORD, MON_EN);
      fire(ev(4'h8, 16'h0, 24'h000104, 24'h0, 24'h0), 4'h0);
      wr(per_pkg::OFS_STATUS_WORD, EXT_CTL);
      fire(ev(4'h8, 16'h0, 24'h000108, 24'h0, 24'h0), 4'h0);
      wr(per_pkg::OFS_EVENT_SELECT, 32'h0000_FFFF);
      wr(per_pkg::OFS_STATUS_WORD, MON_EN | EXT_CTL);
      fire(ev(4'hB, 16'hFFFF, 24'h00010C, 24'h10, 24'h10), 4'h0);
      wr(per_pkg::OFS_EVENT_SELECT, 32'hF000_FFFF);
      fire(ev(4'h0, 16'h0, 24'h000110, 24'h0, 24'h0), 4'h0);
      fire(ev(4'h8, 16'h0, 24'h123456, 24'h0, 24'h0), 4'h8);
   endtask

   task automatic t_types;
      fire(ev(4'h8, 16'h0, 24'h010203, 24'h0, 24'h0), 4'h8);
      fire(ev(4'h0, 16'h8000, 24'h020304, 24'h0, 24'h0), 4'h4);
      fire(ev(4'h2, 16'h0, 24'h030405, 24'h500, 24'h500), 4'h2);
      fire(ev(4'h1, 16'h0, 24'h040506, 24'h600, 24'h600), 4'h1);
      wr(per_pkg::OFS_EVENT_SELECT, 32'hF000_8000);
      fire(ev(4'h0, 16'h8000, 24'h050607, 24'h0, 24'h0), 4'h4);
      fire(ev(4'h0, 16'h7FFF, 24'h060708, 24'h0, 24'h0), 4'h0);
      wr(per_pkg::OFS_EVENT_SELECT, 32'h1000_FFFF);
      fire(ev(4'hB, 16'hFFFF, 24'h070809, 24'h700, 24'h700), 4'h1);
      wr(per_pkg::OFS_EVENT_SELECT, 32'hF000_FFFF);
      fire(ev(4'hB, 16'h0001, 24'h08090A, 24'h800, 24'h800), 4'hF);
      rd(per_pkg::OFS_EVENT_CODE);
      check(rdat, 32'h0000_000F);
      check(resp, per_pkg::RESP_OKAY);
      rd(per_pkg::OFS_EVENT_ADDR);
      check(rdat, 32'h0008_090A);
   endtask

   task automatic t_range;
      wr(per_pkg::OFS_RANGE_START, 32'h0000_1000);
      wr(per_pkg::OFS_RANGE_END, 32'h0000_1FFF);
      fire(ev(4'h1, 16'h0, 24'h000040, 24'hF00000, 24'h000FFF), 4'h0);
      fire(ev(4'h1, 16'h0, 24'h000044, 24'hF00000, 24'h001000), 4'h1);
      fire(ev(4'h1, 16'h0, 24'h000048, 24'hF00000, 24'h001FFF), 4'h1);
      fire(ev(4'h1, 16'h0, 24'h00004C, 24'hF00000, 24'h002000), 4'h0);
      wr(per_pkg::OFS_STATUS_WORD, MON_EN | EXT_CTL | XLATE);
      fire(ev(4'h2, 16'h0, 24'h000050, 24'h001800, 24'hF00000), 4'h2);
      wr(per_pkg::OFS_STATUS_WORD, MON_EN | EXT_CTL);
      assist_mode <= 1'b1;
      fire(ev(4'h2, 16'h0, 24'h000054, 24'h001800, 24'hF00000), 4'h2);
      assist_mode <= 1'b0;
      fire(ev(4'h2, 16'h0, 24'h000058, 24'h001800, 24'hF00000), 4'h0);
   endtask

   task automatic t_irq;
      wr(per_pkg::OFS_IRQ_MASK, 32'h0);
      wr(per_pkg::OFS_IRQ_STATUS, 32'hF);
      rd(per_pkg::OFS_IRQ_STATUS);
      check(rdat, 32'h0);
      fire(ev(4'h1, 16'h0, 24'h000060, 24'h1500, 24'h1500), 4'h1);
      check(irq, 1'b0);
      rd(per_pkg::OFS_IRQ_STATUS);
      check(rdat, 32'h1);
      wr(per_pkg::OFS_IRQ_MASK, 32'h8);
      repeat (2) @(posedge aclk);
      check(irq, 1'b0);
      fire(ev(4'h8, 16'h0, 24'h000064, 24'h0, 24'h0), 4'h8);
      check(irq, 1'b1);
      wr(per_pkg::OFS_IRQ_STATUS, 32'h8);
      repeat (2) @(posedge aclk);
      check(irq, 1'b0);
      rd(per_pkg::OFS_IRQ_STATUS);
      check(rdat, 32'h1);
   endtask

   initial begin
      aclk = 0;
      forever #10 aclk = ~aclk;
   end

   initial begin
      repeat (5000) @(posedge aclk);
      err_count++;
      give_verdict;
   end

   initial begin
      aresetn = 0;
      {awvalid, wvalid, bready, arvalid, rready, cmd_go, assist_mode} = '0;
      awaddr = '0;
      wdata = '0;
      araddr = '0;
      cmd = '0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      t_regs;
      t_gate;
      t_types;
      t_range;
      t_irq;
      give_verdict;
   end
endmodule
`default_nettype wire
